//--- logic/iomsc_pkg.sv
// constants and types for the coax port mode and sleep controller
package iomsc_pkg;

    // serial frame layout: command bit, seven address bits, eight data bits
    localparam int ADDR_W      = 7;
    localparam int DATA_W      = 8;
    localparam int FRAME_BITS  = 16;
    localparam int CMD_BITS    = 8;
    localparam int CNT_W       = 5;
    localparam logic [CNT_W-1:0] CNT_CMD_DONE = 5'h08;
    localparam logic [CNT_W-1:0] CNT_LAST     = 5'h0F;
    localparam logic [CNT_W-1:0] CNT_FULL     = 5'h10;
    localparam int CMD_POS     = 14;
    localparam int RD_CMD_POS  = 7;

    // register addresses
    localparam logic [ADDR_W-1:0] ADDR_GENERAL = 7'h00;
    localparam logic [ADDR_W-1:0] ADDR_DRIVER  = 7'h01;
    localparam logic [ADDR_W-1:0] ADDR_LAUNCH  = 7'h02;
    localparam logic [ADDR_W-1:0] ADDR_CLI     = 7'h03;

    // general_control fields
    localparam int GC_CD_BIT   = 0;
    localparam int GC_MUTE_BIT = 1;
    localparam int GC_EXT_BIT  = 2;
    localparam int GC_SLP_LO   = 3;
    localparam int GC_SLP_HI   = 4;

    // output driver fields
    localparam int DRV_SW_HI   = 7;
    localparam int DRV_SW_LO   = 5;
    localparam int DRV_CM_HI   = 4;
    localparam int DRV_CM_LO   = 2;

    // cable length field
    localparam int CLI_HI      = 7;
    localparam int CLI_LO      = 3;
    localparam int CLI_W       = 5;

    // sleep field codes
    typedef enum logic [1:0] {
        SLEEP_NEVER = 2'h0,
        SLEEP_AUTO  = 2'h1,
        SLEEP_FORCE = 2'h2,
        SLEEP_RSVD  = 2'h3
    } iomsc_sleep_t;

    // reset values
    localparam logic [2:0] SWING_RST   = 3'h3;
    localparam logic [2:0] CM_RST      = 3'h1;
    localparam logic [7:0] LAUNCH_RST  = 8'h00;
    localparam logic [7:0] BYTE_ZERO   = 8'h00;

    // equalizer power states
    typedef enum logic [2:0] {
        EQ_ACTIVE = 3'b001,
        EQ_HOLD   = 3'b010,
        EQ_DOWN   = 3'b100
    } iomsc_eq_t;

    // power-down timing
    localparam int PD_MAX_NS     = 200000;
    localparam int CLK_PERIOD_NS = 8;
    localparam int PD_MAX_CYC    = PD_MAX_NS / CLK_PERIOD_NS;
    localparam int SYNC_LAT_CYC  = 3;
    localparam int HOLD_W        = 16;

endpackage

//--- logic/iomsc_top.sv
// coax port mode, sleep and serial register controller
`timescale 1ns/100ps
// Summary of operation
// - Sleep codes 00 never and 11 reserved keep the equalizer enabled.
// - Sleep code 10 forces equalizer power-down whatever the input.
// - In every sleep mode, only driver enable picks direction.
// - Carrier output is high without signal, low with valid signal.
// - Auto sleep powers down without signal, up again with signal.
// - Sleep field resets to auto; software may change it later.
// - Auto sleep power-down completes under 200 us after loss.
// - In auto sleep the equalizer wakes at once when a signal is detected.
// - Common mode code defaults to 1.25 V, selectable in 200 mV steps.
// - Swing code defaults to 700 mV, selectable in 100 mV steps.
// - Sleep power-down overrides the mute setting.
// - Swing lives in bits 7:5 of register 01h, reset 011.
// - Common mode lives in bits 4:2 of register 01h, reset 001.
// - Write frame: zero bit, seven address, eight data, 16 bits.
module iomsc_top #(
    parameter int SLEEP_HOLDOFF_CYC =
        iomsc_pkg::PD_MAX_CYC - iomsc_pkg::SYNC_LAT_CYC - 2
) (
    // core clock and reset
    input  wire logic                     core_clk,
    input  wire logic                     rst,
    // serial register port
    input  wire logic                     link_sck,
    input  wire logic                     ss_n,
    input  wire logic                     mosi,
    output logic                          miso_o,
    output logic                          miso_oe,
    // analog front-end status
    input  wire logic                     signal_detect,
    input  wire logic [iomsc_pkg::CLI_W-1:0] cable_length_code,
    // mode pin
    input  wire logic                     tx_enable_pin,
    // status and control toward the analog blocks
    output logic                          carrier_present_n,
    output logic                          eq_power_on,
    output logic                          eq_output_active,
    output logic                          cable_driver_on,
    output logic                          ext_reach_on,
    output logic [2:0]                    swing_sel,
    output logic [2:0]                    output_common_mode,
    output logic [7:0]                    launch_amp_sel
);
    import iomsc_pkg::*;

    localparam logic [HOLD_W-1:0] HOLD_LAST =
        HOLD_W'(SLEEP_HOLDOFF_CYC - 1);

    // ---------------- core domain state ----------------
    logic                    link_rst_r;
    logic                    sd_s1_r;
    logic                    sd_s2_r;
    logic                    tx_s1_r;
    logic                    tx_s2_r;
    logic                    ss_s1_r;
    logic                    ss_s2_r;
    logic [CLI_W-1:0]        cli_s1_r;
    logic [CLI_W-1:0]        cli_s2_r;
    logic                    tgl_s1_r;
    logic                    tgl_s2_r;
    logic                    tgl_s3_r;
    logic                    mute_r;
    logic                    ext_r;
    iomsc_sleep_t            sleep_r;
    logic [2:0]              swing_r;
    logic [2:0]              cm_r;
    logic [7:0]              launch_r;
    iomsc_eq_t               eq_state_r;
    iomsc_eq_t               eq_state_nxt;
    logic [HOLD_W-1:0]       hold_cnt_r;
    logic [HOLD_W-1:0]       hold_cnt_nxt;
    logic [4*DATA_W-1:0]     image_r;
    logic                    carrier_n_r;
    logic                    eq_power_r;
    logic                    eq_out_r;
    logic                    drv_on_r;

    // ---------------- link domain state ----------------
    logic [CNT_W-1:0]        bit_cnt_r;
    logic [FRAME_BITS-1:0]   in_sr_r;
    logic [FRAME_BITS-2:0]   wr_word_r;
    logic                    wr_tgl_r;
    logic [DATA_W-1:0]       out_sr_r;
    logic                    miso_oe_r;

    // link write word is cleared by the core reset, the link shifters by each frame end
    always_ff @(posedge core_clk) begin
        link_rst_r <= rst;
    end

    // frame shifter; deselect ends the frame, the clock may stop anytime
    always_ff @(posedge link_sck or posedge ss_n) begin
        if (ss_n) begin
            bit_cnt_r <= '0;
            in_sr_r   <= '0;
        end else begin
            if (bit_cnt_r != CNT_FULL) begin
                bit_cnt_r <= bit_cnt_r + 5'h01;
            end
            in_sr_r <= {in_sr_r[FRAME_BITS-2:0], mosi};
        end
    end

    wire frame_write = !ss_n && (bit_cnt_r == CNT_LAST)
                       && !in_sr_r[CMD_POS];

    // completed write word and its event toggle
    always_ff @(posedge link_sck or posedge link_rst_r) begin
        if (link_rst_r) begin
            wr_word_r <= '0;
            wr_tgl_r  <= 1'b0;
        end else if (frame_write) begin
            wr_word_r <= {in_sr_r[FRAME_BITS-3:0], mosi};
            wr_tgl_r  <= !wr_tgl_r;
        end
    end

    // read data: image is held stable by the core while a frame is open
    wire [ADDR_W-1:0] rd_addr = in_sr_r[ADDR_W-1:0];
    wire              rd_cmd  = in_sr_r[RD_CMD_POS];
    wire              rd_load = (bit_cnt_r == CNT_CMD_DONE) && rd_cmd;
    wire [DATA_W-1:0] rd_word =
        (rd_addr == ADDR_GENERAL) ? image_r[0*DATA_W +: DATA_W] :
        (rd_addr == ADDR_DRIVER)  ? image_r[1*DATA_W +: DATA_W] :
        (rd_addr == ADDR_LAUNCH)  ? image_r[2*DATA_W +: DATA_W] :
        (rd_addr == ADDR_CLI)     ? image_r[3*DATA_W +: DATA_W] :
                                    BYTE_ZERO;

    // output shifts on falling edges, first bit after the eighth clock
    always_ff @(negedge link_sck or posedge ss_n) begin
        if (ss_n) begin
            out_sr_r  <= '0;
            miso_oe_r <= 1'b0;
        end else if (rd_load && !miso_oe_r) begin
            out_sr_r  <= rd_word;
            miso_oe_r <= 1'b1;
        end else begin
            out_sr_r  <= {out_sr_r[DATA_W-2:0], 1'b0};
        end
    end

    assign miso_o  = out_sr_r[DATA_W-1];
    assign miso_oe = miso_oe_r;

    // ---------------- crossings into the core ----------------
    // detect is an analog level with no relation to the core clock
    always_ff @(posedge core_clk) begin
        sd_s1_r <= signal_detect;
        sd_s2_r <= sd_s1_r;
    end

    // mode pin is free running; direction follows it only
    always_ff @(posedge core_clk) begin
        tx_s1_r <= tx_enable_pin;
        tx_s2_r <= tx_s1_r;
    end

    // select is synced only to gate the read-back image refresh
    always_ff @(posedge core_clk) begin
        ss_s1_r <= ss_n;
        ss_s2_r <= ss_s1_r;
    end

    // cable length is quasi-static, so a plain bus sync is enough
    always_ff @(posedge core_clk) begin
        cli_s1_r <= cable_length_code;
        cli_s2_r <= cli_s1_r;
    end

    // third stage only feeds the edge detect on the write toggle
    always_ff @(posedge core_clk) begin
        tgl_s1_r <= wr_tgl_r;
        tgl_s2_r <= tgl_s1_r;
        tgl_s3_r <= tgl_s2_r;
    end

    // word is stable: it only changes one full frame after the toggle
    wire              wr_stb   = (tgl_s2_r ^ tgl_s3_r) && !rst;
    wire [ADDR_W-1:0] wr_addr  = wr_word_r[FRAME_BITS-2:DATA_W];
    wire [DATA_W-1:0] wr_data  = wr_word_r[DATA_W-1:0];
    wire              wr_gen   = wr_stb && (wr_addr == ADDR_GENERAL);
    wire              wr_drv   = wr_stb && (wr_addr == ADDR_DRIVER);
    wire              wr_lau   = wr_stb && (wr_addr == ADDR_LAUNCH);

    // ---------------- registers ----------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            mute_r <= 1'b0;
        end else if (wr_gen) begin
            mute_r <= wr_data[GC_MUTE_BIT];
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            ext_r <= 1'b0;
        end else if (wr_gen) begin
            ext_r <= wr_data[GC_EXT_BIT];
        end
    end

    // reserved code 11 is stored as written and read back unchanged
    always_ff @(posedge core_clk) begin
        if (rst) begin
            sleep_r <= SLEEP_AUTO;
        end else if (wr_gen) begin
            sleep_r <= iomsc_sleep_t'(wr_data[GC_SLP_HI:GC_SLP_LO]);
        end
    end

    // swing and common mode share one write but are kept apart
    always_ff @(posedge core_clk) begin
        if (rst) begin
            swing_r <= SWING_RST;
        end else if (wr_drv) begin
            swing_r <= wr_data[DRV_SW_HI:DRV_SW_LO];
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            cm_r <= CM_RST;
        end else if (wr_drv) begin
            cm_r <= wr_data[DRV_CM_HI:DRV_CM_LO];
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            launch_r <= LAUNCH_RST;
        end else if (wr_lau) begin
            launch_r <= wr_data;
        end
    end

    // read-back image, frozen while a frame is selected
    wire [DATA_W-1:0] gen_img = {3'h0, sleep_r, ext_r, mute_r, sd_s2_r};
    wire [DATA_W-1:0] drv_img = {swing_r, cm_r, 2'h0};
    wire [DATA_W-1:0] cli_img = {cli_s2_r, 3'h0};

    always_ff @(posedge core_clk) begin
        if (rst) begin
            image_r <= '0;
        end else if (ss_s2_r) begin
            image_r <= {cli_img, launch_r, drv_img, gen_img};
        end
    end

    // ---------------- equalizer power sequencing ----------------
    always_comb begin
        eq_state_nxt = eq_state_r;
        hold_cnt_nxt = '0;
        unique case (sleep_r)
            SLEEP_FORCE: eq_state_nxt = EQ_DOWN;
            SLEEP_NEVER,
            SLEEP_RSVD:  eq_state_nxt = EQ_ACTIVE;
            SLEEP_AUTO: begin
                if (sd_s2_r) begin
                    eq_state_nxt = EQ_ACTIVE;
                end else begin
                    unique case (eq_state_r)
                        EQ_ACTIVE: eq_state_nxt = EQ_HOLD;
                        EQ_HOLD: begin
                            if (hold_cnt_r >= HOLD_LAST) begin
                                eq_state_nxt = EQ_DOWN;
                            end else begin
                                hold_cnt_nxt = hold_cnt_r + 16'h0001;
                            end
                        end
                        EQ_DOWN:   eq_state_nxt = EQ_DOWN;
                        default:   eq_state_nxt = EQ_DOWN;
                    endcase
                end
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            eq_state_r <= EQ_ACTIVE;
            hold_cnt_r <= '0;
        end else begin
            eq_state_r <= eq_state_nxt;
            hold_cnt_r <= hold_cnt_nxt;
        end
    end

    // the driver pin alone sets direction; sleep does not touch it
    wire eq_on_nxt  = (eq_state_nxt != EQ_DOWN);
    wire eq_out_nxt = eq_on_nxt && !mute_r;

    // carrier flag idles high, meaning no signal, out of reset
    always_ff @(posedge core_clk) begin
        if (rst) begin
            carrier_n_r <= 1'b1;
        end else begin
            carrier_n_r <= !sd_s2_r;
        end
    end

    // powered out of reset; auto sleep then counts down if idle
    always_ff @(posedge core_clk) begin
        if (rst) begin
            eq_power_r <= 1'b1;
        end else begin
            eq_power_r <= eq_on_nxt;
        end
    end

    // sleep wins over mute: outputs die with the power
    always_ff @(posedge core_clk) begin
        if (rst) begin
            eq_out_r <= 1'b1;
        end else begin
            eq_out_r <= eq_out_nxt;
        end
    end

    // driver starts off so the port never drives the cable unasked
    always_ff @(posedge core_clk) begin
        if (rst) begin
            drv_on_r <= 1'b0;
        end else begin
            drv_on_r <= tx_s2_r;
        end
    end

    assign carrier_present_n  = carrier_n_r;
    assign eq_power_on        = eq_power_r;
    assign eq_output_active   = eq_out_r;
    assign cable_driver_on    = drv_on_r;
    assign ext_reach_on       = ext_r;
    assign swing_sel          = swing_r;
    assign output_common_mode = cm_r;
    assign launch_amp_sel     = launch_r;

endmodule // iomsc_top

//--- tb/iomsc_sva.sv
// pin level assertions for the coax port mode and sleep controller
`timescale 1ns/100ps
module iomsc_sva (
    // clock and reset
    input wire logic       core_clk,
    input wire logic       rst,
    // watched pins
    input wire logic       ss_n,
    input wire logic       miso_oe,
    input wire logic       signal_detect,
    input wire logic       tx_enable_pin,
    input wire logic       carrier_present_n,
    input wire logic       eq_power_on,
    input wire logic       eq_output_active,
    input wire logic       cable_driver_on,
    input wire logic       ext_reach_on,
    input wire logic [2:0] swing_sel,
    input wire logic [2:0] output_common_mode,
    input wire logic [7:0] launch_amp_sel
);
    logic [2:0] up_r;
    logic [4:0] idle_r;
    // past pin values mean nothing until the sync pipes refill
    always_ff @(posedge core_clk) begin
        if (rst) up_r <= 3'h0;
        else if (up_r != 3'h7) up_r <= up_r + 3'h1;
    end
    always_ff @(posedge core_clk) begin
        if (rst || !ss_n) idle_r <= 5'h00;
        else if (idle_r != 5'h1F) idle_r <= idle_r + 5'h01;
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    a_carrier_follows: assert property (
        up_r > 3'h5 |-> carrier_present_n == !$past(signal_detect, 3))
        else $error("carrier flag out of step with detect");
    a_driver_follows: assert property (
        up_r > 3'h5 |-> cable_driver_on == $past(tx_enable_pin, 3))
        else $error("driver enable out of step with pin");
    a_sleep_mutes: assert property (
        !eq_power_on && $past(!eq_power_on) |-> !eq_output_active)
        else $error("outputs live while asleep");
    a_miso_quiet: assert property (
        ss_n && $past(ss_n) |-> !miso_oe)
        else $error("serial out driven while deselected");
    a_reset_values: assert property (
        $fell(rst) |-> swing_sel == 3'h3 && output_common_mode == 3'h1 &&
        launch_amp_sel == 8'h00 && eq_power_on && !cable_driver_on)
        else $error("bad reset values");
    a_idle_steady: assert property (
        idle_r > 5'h0C |-> $stable({swing_sel, output_common_mode,
        launch_amp_sel, ext_reach_on}))
        else $error("register changed with no frame");
    // power rises three edges after the detect pin: sync plus flop; falls wait out the hold-off
    a_fall_cause: assert property (
        $fell(eq_power_on) && up_r > 3'h5
        |-> idle_r < 5'h14 || !$past(signal_detect, 3))
        else $error("power dropped with signal and no write");
    a_rise_cause: assert property (
        $rose(eq_power_on) && up_r > 3'h5
        |-> idle_r < 5'h14 || $past(signal_detect, 3))
        else $error("power rose with no signal and no write");
    c_frame: cover property (!ss_n ##1 ss_n);
    c_sleep: cover property ($fell(eq_power_on));
    c_read: cover property ($rose(miso_oe));
endmodule // iomsc_sva

bind iomsc_top iomsc_sva u_sva (.core_clk, .rst, .ss_n, .miso_oe,
    .signal_detect, .tx_enable_pin, .carrier_present_n, .eq_power_on,
    .eq_output_active, .cable_driver_on, .ext_reach_on, .swing_sel,
    .output_common_mode, .launch_amp_sel);

//--- tb/iomsc_host.sv
// serial register master standing in for the system controller
`timescale 1ns/100ps
module iomsc_host (
    // serial pins
    output logic      link_sck,
    output logic      ss_n,
    output logic      mosi,
    input wire logic  miso_o,
    input wire logic  miso_oe
);
    initial begin
        link_sck = 1'h0;
        ss_n = 1'h1;
        mosi = 1'h0;
    end
    // clock stands still between frames; a released line keeps toggling
    task automatic xfer(input int n, input logic [15:0] f,
                        output logic [7:0] d);
        d = 8'h00;
        ss_n = 1'h0;
        for (int i = 0; i < n; i++) begin
            mosi = (f[15] && i > 7) ? ~mosi : f[15-i];
            #3 link_sck = 1'h1;
            if (i > 7) d = {d[6:0], miso_oe ? miso_o : ~miso_o};
            #3 link_sck = 1'h0;
        end
        #3 ss_n = 1'h1;
        mosi = ~mosi;
    endtask
endmodule // iomsc_host

//--- tb/tb_top.sv
// self-checking bench for the coax port mode and sleep controller
`timescale 1ns/100ps
module tb_top;
    import iomsc_pkg::*;
    localparam int HOLD = 8;
    logic core_clk = 1'h0, rst = 1'h1, signal_detect = 1'h0;
    logic tx_enable_pin = 1'h0;
    logic [4:0] cable_length_code = 5'h00;
    logic link_sck, ss_n, mosi, miso_o, miso_oe, carrier_present_n;
    logic eq_power_on, eq_output_active, cable_driver_on, ext_reach_on;
    logic [2:0] swing_sel, output_common_mode;
    logic [7:0] launch_amp_sel, d;
    int errors = 0, tests_run = 0;
    int m_slp = 1, m_mute = 0, m_ext = 0, m_sw = 3, m_cm = 1, m_la = 0;
    always #4 core_clk = ~core_clk;
    iomsc_top #(.SLEEP_HOLDOFF_CYC(HOLD)) dut (.core_clk, .rst, .link_sck,
        .ss_n, .mosi, .miso_o, .miso_oe, .signal_detect, .cable_length_code,
        .tx_enable_pin, .carrier_present_n, .eq_power_on, .eq_output_active,
        .cable_driver_on, .ext_reach_on, .swing_sel, .output_common_mode,
        .launch_amp_sel);
    iomsc_host host (.link_sck, .ss_n, .mosi, .miso_o, .miso_oe);
    task automatic complete_run();
        $display("errors %0d tests_run %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        host.xfer(16, {1'h1, a, 8'h00}, d);
        repeat (4) @(negedge core_clk);
        chk(d, e);
    endtask
    task automatic check_all();
        logic pw;
        pw = (m_slp == 2) ? 1'h0 : (m_slp == 1) ? signal_detect : 1'h1;
        rd(ADDR_GENERAL, {3'h0, 2'(m_slp), 1'(m_ext), 1'(m_mute),
            signal_detect});
        rd(ADDR_DRIVER, {3'(m_sw), 3'(m_cm), 2'h0});
        rd(ADDR_LAUNCH, 8'(m_la));
        chk({7'h0, eq_power_on}, {7'h0, pw});
        chk({7'h0, eq_output_active}, {7'h0, pw & !m_mute});
        chk({2'h0, swing_sel, output_common_mode},
            {2'h0, 3'(m_sw), 3'(m_cm)});
        chk({7'h0, carrier_present_n},
            {7'h0, !signal_detect});
        chk({7'h0, ext_reach_on}, 8'(m_ext));
        chk(launch_amp_sel, 8'(m_la));
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] v);
        host.xfer(16, {1'h0, a, v}, d);
        if (a == ADDR_GENERAL) begin
            m_slp = v[4:3];
            m_mute = v[1];
            m_ext = v[2];
        end
        if (a == ADDR_DRIVER) begin
            m_sw = v[7:5];
            m_cm = v[4:2];
        end
        if (a == ADDR_LAUNCH) m_la = v;
        repeat (12) @(negedge core_clk);
        check_all();
    endtask
    // a wait that runs out ends the run at once
    task automatic wait_pw(input logic v, input int lim);
        int n;
        n = 0;
        while (eq_power_on !== v && n < lim) begin
            @(negedge core_clk);
            n++;
        end
        chk({7'h0, eq_power_on}, {7'h0, v});
        if (eq_power_on !== v) complete_run();
    endtask
    initial begin
        void'($urandom(26043));
        @(negedge core_clk);
        cable_length_code = 5'($urandom);
        repeat (15) @(negedge core_clk);
        rst = 1'h0;
        repeat (4) @(negedge core_clk);
        check_all();
        rd(ADDR_CLI, {cable_length_code, 3'h0});
        rd(7'h55, 8'h00);
        tx_enable_pin = 1'h0;
        signal_detect = 1'h1;
        wr(ADDR_GENERAL, 8'h08);
        wr(ADDR_LAUNCH, 8'h30);
        for (int i = 0; i < 4; i++)
            wr(ADDR_DRIVER, 8'($urandom));
        for (int s = 0; s < 4; s++)
            wr(ADDR_GENERAL, {3'h7, 2'(s), 3'($urandom)});
        wr(ADDR_CLI, 8'hFF);
        rd(ADDR_CLI, {cable_length_code, 3'h0});
        host.xfer(12, {1'h0, ADDR_LAUNCH, 8'hFF}, d);
        repeat (12) @(negedge core_clk);
        check_all();
        wr(ADDR_GENERAL, 8'h08);
        signal_detect = 1'h0;
        wait_pw(1'h0, HOLD + 12);
        signal_detect = 1'h1;
        wait_pw(1'h1, 4);
        tx_enable_pin = 1'h1;
        repeat (6) @(negedge core_clk);
        chk({7'h0, cable_driver_on}, 8'h01);
        check_all();
        tx_enable_pin = 1'h0;
        wr(ADDR_GENERAL, 8'h10);
        chk({7'h0, cable_driver_on}, 8'h00);
        tx_enable_pin = 1'h1;
        repeat (6) @(negedge core_clk);
        chk({7'h0, cable_driver_on & !eq_power_on}, 8'h01);
        complete_run();
    end
endmodule // tb_top
